//--- shared/ast_pkg.sv
// Shared constants, configuration carrier and state records of the serial transceiver
package ast_pkg;

	// Widths and sizes
	localparam int AST_BAUD_W = 13;
	localparam int AST_DATA_W = 9;
	localparam int AST_FIFO_DEPTH = 16;

	// Bit timing: sixteen sample ticks per bit, counted 0..15 for RT1..RT16
	localparam logic [3:0] AST_SUB_LAST = 4'hf;
	localparam logic [3:0] AST_RT3 = 4'h2;
	localparam logic [3:0] AST_RT5 = 4'h4;
	localparam logic [3:0] AST_RT7 = 4'h6;
	localparam logic [3:0] AST_RT8 = 4'h7;
	localparam logic [3:0] AST_RT9 = 4'h8;
	localparam logic [3:0] AST_RT10 = 4'h9;
	localparam logic [3:0] AST_RESYNC_LO = 4'ha;
	localparam logic [3:0] AST_RESYNC_HI = 4'h1;

	// Frame lengths in bit times
	localparam logic [3:0] AST_FRAME_BASE = 4'ha;
	localparam logic [3:0] AST_LONG_BREAK_EXTRA = 4'h3;
	localparam logic [3:0] AST_DATA_BITS_8 = 4'h8;

	typedef enum logic [0:0] {
		AST_TX_IDLE = 1'b0,
		AST_TX_SHIFT = 1'b1
	} ast_tx_state_t;

	typedef enum logic [1:0] {
		AST_RX_HUNT = 2'b00,
		AST_RX_START = 2'b01,
		AST_RX_DATA = 2'b10
	} ast_rx_state_t;

	// Frame format selections
	typedef struct packed {
		logic nine_bit;
		logic two_stop;
		logic long_break;
	} ast_cfg_t;

	typedef struct packed {
		ast_tx_state_t st;
		logic [11:0] shift;
		logic fill;
		logic [3:0] bits_left;
		logic [3:0] sub;
		logic [8:0] tdb;
		logic tdb_full;
		logic pre_pend;
		logic brk_pend;
		logic te_prev;
		logic sbk_prev;
		logic done;
		logic txd;
		logic oe_n;
	} ast_tx_t;

	typedef struct packed {
		ast_rx_state_t st;
		logic sync1;
		logic sync2;
		logic prev;
		logic [2:0] hist;
		logic [3:0] rt;
		logic [1:0] zeros;
		logic [2:0] smp;
		logic [3:0] bit_idx;
		logic [8:0] shreg;
		logic bad_stop;
		logic [8:0] data;
		logic rbf;
		logic ovr;
		logic fe;
		logic armed;
	} ast_rx_t;

	localparam ast_tx_t AST_TX_RESET = '{st: AST_TX_IDLE, shift: 12'hfff, fill: 1'b1,
		bits_left: 4'h0, sub: 4'h0, tdb: 9'h000, tdb_full: 1'b0, pre_pend: 1'b0,
		brk_pend: 1'b0, te_prev: 1'b0, sbk_prev: 1'b0, done: 1'b1, txd: 1'b1, oe_n: 1'b1};

	localparam ast_rx_t AST_RX_RESET = '{st: AST_RX_HUNT, sync1: 1'b0, sync2: 1'b0,
		prev: 1'b0, hist: 3'h0, rt: 4'h0, zeros: 2'h0, smp: 3'h0, bit_idx: 4'h0,
		shreg: 9'h000, bad_stop: 1'b0, data: 9'h000, rbf: 1'b0, ovr: 1'b0, fe: 1'b0,
		armed: 1'b0};

endpackage

//--- hw/ast_baud.sv
// Baud divider producing the sixteen-times sample tick
`timescale 1ns/1ps
module ast_baud #(
	parameter int W = 13
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] div_i,
	output logic tick_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} ast_baud_st_t;

	ast_baud_st_t q, d;

	// Divisor zero parks the counter, so no tick ever leaves
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (div_i == '0) begin
			d.cnt = '0;
		end else if (q.cnt >= div_i - W'(1)) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_o = q.tick;
endmodule

//--- hw/ast_fifo.sv
// Transmit FIFO with valid/ready on both sides and registered flags
`timescale 1ns/1ps
module ast_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic space;
		logic avail;
	} ast_fifo_st_t;

	ast_fifo_st_t q, d;
	logic push, pop;

	// Flags are kept as flops so ready and valid leave without logic behind them
	always_comb begin
		d = q;
		push = in_valid_i && q.space;
		pop = out_ready_i && q.avail;
		if (push) begin
			d.mem[q.wr] = in_data_i;
			d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
		end
		if (pop) begin
			d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		d.space = d.cnt != (AW+1)'(DEPTH);
		d.avail = d.cnt != '0;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
			q.space <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign in_ready_o = q.space;
	assign out_valid_o = q.avail;
	assign out_data_o = q.mem[q.rd];
endmodule

//--- hw/ast_top.sv
// Full-duplex asynchronous serial transceiver: baud divider, transmitter, receiver
// Operation
// R01: Independent transmitter and receiver, one shared baud generator
// R02: Baud generator divides bus clock by modulo
// R03: Receiver resynchronises on every falling line edge; code resyncs only on edges from RT11 through RT2
// R04: Remote rate within about 4.5 or 4 percent
// R05: Output idles high after reset; inversion flips it
// R06: Enabling transmitter queues one idle preamble frame
// R07: Shift frame is 10, 11 or 12 bits
// R08: Buffer moves to shifter on tick, then empty
// R09: Software checks status before writing data
// R10: Nothing waiting after stop: set done, idle high
// R11: Pin kept until queued and current frames finish; code releases the pin with a buffered data character unsent once disabled
// R12: Break control queues breaks while held set
// R13: Break lasts 10 to 15 bit times
// R14: Software pulses break control once per break
// R15: Enable low then high queues one idle
// R16: Receiver enable activates; receive inversion flips input
// R17: Start zero, 8/9 data LSB first, stop ones
// R18: Full register on arrival sets overrun, drops character; code drops it without setting overrun while a framing error stands
// R19: Full flag cleared by status then data read
// R20: Sixteen samples per bit, majority of three
// R21: Sixteen ticks per bit; divisor zero halts
// R22: Stop bit sampled zero sets framing error
`timescale 1ns/1ps
module ast_top #(
	parameter int BAUD_W = ast_pkg::AST_BAUD_W,
	parameter int FIFO_DEPTH = ast_pkg::AST_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [BAUD_W-1:0] baud_div_i,
	input wire logic tx_enable_i,
	input wire logic rx_enable_i,
	input wire logic tx_polarity_flip_i,
	input wire logic rx_polarity_flip_i,
	input wire logic nine_bit_sel_i,
	input wire logic two_stop_sel_i,
	input wire logic long_break_sel_i,
	input wire logic send_break_ctrl_i,
	input wire logic [ast_pkg::AST_DATA_W-1:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic txd_o,
	output logic txd_oe_n_o,
	output logic tx_buffer_empty_o,
	output logic tx_done_flag_o,
	input wire logic rxd_i,
	input wire logic status_read_i,
	input wire logic data_read_i,
	output logic [ast_pkg::AST_DATA_W-1:0] rx_data_o,
	output logic rx_buffer_full_o,
	output logic overrun_flag_o,
	output logic frame_error_flag_o
);
	ast_pkg::ast_cfg_t cfg;
	ast_pkg::ast_tx_t tq, td;
	ast_pkg::ast_rx_t rq, rd;
	logic tick;
	logic [ast_pkg::AST_DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_take;
	logic [3:0] frame_bits;
	logic [3:0] break_bits;
	logic [3:0] data_bits;
	logic [3:0] last_idx;
	logic any_pend;
	logic s;
	logic vote;
	logic fall;
	logic rx_clear;

	// Format selections travel together to both directions
	assign cfg = '{nine_bit: nine_bit_sel_i, two_stop: two_stop_sel_i,
		long_break: long_break_sel_i};

	// One tick source serves both directions; they never share any other state
	ast_baud #(
		.W(BAUD_W)
	) u_baud (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.div_i(baud_div_i),
		.tick_o(tick)
	); // R01 R02 R21

	// Characters queue here before the transmit data buffer
	ast_fifo #(
		.W(ast_pkg::AST_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_data_i(tx_data_i),
		.in_valid_i(tx_valid_i),
		.in_ready_o(tx_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_take)
	);

	// Frame lengths in bit times for the current format
	always_comb begin
		frame_bits = ast_pkg::AST_FRAME_BASE + 4'(cfg.nine_bit) + 4'(cfg.two_stop); // R07
		break_bits = frame_bits; // R13
		if (cfg.long_break) begin
			break_bits = frame_bits + ast_pkg::AST_LONG_BREAK_EXTRA; // R13
		end
		data_bits = ast_pkg::AST_DATA_BITS_8 + 4'(cfg.nine_bit);
		last_idx = data_bits + 4'(cfg.two_stop) + 4'h1;
	end

	// Buffer refills from the FIFO only while the transmitter is enabled
	assign fifo_take = !tq.tdb_full && tx_enable_i;

	// Transmitter next state
	always_comb begin
		td = tq;
		td.te_prev = tx_enable_i;
		td.sbk_prev = send_break_ctrl_i;
		if (fifo_take && fifo_valid) begin
			td.tdb = fifo_data;
			td.tdb_full = 1'b1;
		end
		// A rising enable queues the preamble, and a 0-then-1 pulse an idle frame
		if (tx_enable_i && !tq.te_prev) begin
			td.pre_pend = 1'b1; // R06 R15
		end
		if (send_break_ctrl_i && !tq.sbk_prev) begin
			td.brk_pend = 1'b1; // R12 R14
		end
		case (tq.st)
			ast_pkg::AST_TX_IDLE: begin
				if (tick) begin
					// Idle first, then break, then data; loads wait for a tick
					if (tq.pre_pend) begin
						td.pre_pend = 1'b0;
						td.shift = 12'hfff;
						td.fill = 1'b1;
						td.bits_left = frame_bits; // R06
						td.sub = 4'h0;
						td.st = ast_pkg::AST_TX_SHIFT;
					end else if (tq.brk_pend) begin
						// Still held when the break loads: queue another
						td.brk_pend = send_break_ctrl_i; // R12
						td.shift = 12'h000;
						td.fill = 1'b0;
						td.bits_left = break_bits; // R13
						td.sub = 4'h0;
						td.st = ast_pkg::AST_TX_SHIFT;
					end else if (tq.tdb_full && tx_enable_i) begin
						td.tdb_full = 1'b0; // R08
						td.fill = 1'b1;
						if (cfg.nine_bit) begin
							td.shift = {2'b11, tq.tdb, 1'b0}; // R07 R17
						end else begin
							td.shift = {3'b111, tq.tdb[7:0], 1'b0}; // R07 R17
						end
						td.bits_left = frame_bits;
						td.sub = 4'h0;
						td.st = ast_pkg::AST_TX_SHIFT; // R08
					end
				end
			end
			ast_pkg::AST_TX_SHIFT: begin
				if (tick) begin
					td.sub = tq.sub + 4'h1;
					// One bit lasts sixteen ticks
					if (tq.sub == ast_pkg::AST_SUB_LAST) begin
						td.shift = {tq.fill, tq.shift[11:1]}; // R17 R21
						td.bits_left = tq.bits_left - 4'h1;
						if (tq.bits_left == 4'h1) begin
							td.st = ast_pkg::AST_TX_IDLE;
						end
					end
				end
			end
			default: begin
				td.st = ast_pkg::AST_TX_IDLE;
			end
		endcase
		any_pend = td.pre_pend || td.brk_pend || (td.tdb_full && tx_enable_i);
		// Done only when idle with nothing left to send
		td.done = (td.st == ast_pkg::AST_TX_IDLE) && !any_pend; // R10
		// Line idles high unless inverted; inversion covers the whole waveform
		if (td.st == ast_pkg::AST_TX_SHIFT) begin
			td.txd = td.shift[0] ^ tx_polarity_flip_i; // R05
		end else begin
			td.txd = 1'b1 ^ tx_polarity_flip_i; // R05 R10
		end
		// Pin is held while a frame is in flight or an idle or break is queued, even if disabled
		td.oe_n = !(tx_enable_i || td.st == ast_pkg::AST_TX_SHIFT
			|| td.pre_pend || td.brk_pend); // R11 R15
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tq <= ast_pkg::AST_TX_RESET; // R05
		end else begin
			tq <= td;
		end
	end

	// Receiver helpers: sample value, bit vote and falling edge
	always_comb begin
		s = rq.sync2 ^ rx_polarity_flip_i; // R16
		vote = (rq.smp[0] & rq.smp[1]) | (rq.smp[0] & s) | (rq.smp[1] & s); // R20
		fall = rq.prev && !s;
	end

	// Read sequence: status read while full arms, the data read then clears
	assign rx_clear = data_read_i && rq.armed; // R19

	// Receiver next state
	always_comb begin
		rd = rq;
		rd.sync1 = rxd_i;
		rd.sync2 = rq.sync1;
		if (status_read_i && rq.rbf) begin
			rd.armed = 1'b1; // R19
		end
		// Clear applies first so a same-cycle arrival still sets its flags
		if (rx_clear) begin
			rd.rbf = 1'b0; // R19
			rd.ovr = 1'b0;
			rd.fe = 1'b0;
			rd.armed = 1'b0;
		end
		if (!rx_enable_i) begin
			rd.st = ast_pkg::AST_RX_HUNT; // R16
			rd.hist = 3'h0;
		end else if (tick) begin
			rd.prev = s;
			case (rq.st)
				ast_pkg::AST_RX_HUNT: begin
					rd.hist = {rq.hist[1:0], s};
					// Edge means a zero after three ones
					if (rq.hist == 3'h7 && !s) begin
						rd.st = ast_pkg::AST_RX_START; // R20
						rd.rt = 4'h1;
						rd.zeros = 2'h0;
					end
				end
				ast_pkg::AST_RX_START: begin
					rd.rt = rq.rt + 4'h1;
					if ((rq.rt == ast_pkg::AST_RT3 || rq.rt == ast_pkg::AST_RT5
						|| rq.rt == ast_pkg::AST_RT7) && !s) begin
						rd.zeros = rq.zeros + 2'h1;
					end
					// Qualify the start bit by two of three early samples
					if (rq.rt == ast_pkg::AST_RT7) begin
						if (rd.zeros >= 2'h2) begin
							rd.st = ast_pkg::AST_RX_DATA; // R20
							rd.bit_idx = 4'h0;
							rd.bad_stop = 1'b0;
						end else begin
							rd.st = ast_pkg::AST_RX_HUNT;
							rd.hist = 3'h0;
						end
					end
				end
				ast_pkg::AST_RX_DATA: begin
					rd.rt = rq.rt + 4'h1;
					// Edges near the bit boundary realign timing; mid-bit ones are noise
					if (fall && (rq.rt >= ast_pkg::AST_RESYNC_LO
						|| rq.rt <= ast_pkg::AST_RESYNC_HI)) begin
						rd.rt = 4'h1; // R03
					end
					if (rq.rt == ast_pkg::AST_RT8) begin
						rd.smp[0] = s;
					end
					if (rq.rt == ast_pkg::AST_RT9) begin
						rd.smp[1] = s;
					end
					if (rq.rt == ast_pkg::AST_RT10) begin
						rd.bit_idx = rq.bit_idx + 4'h1;
						if (rq.bit_idx != 4'h0 && rq.bit_idx <= data_bits) begin
							rd.shreg = {vote, rq.shreg[8:1]}; // R17 R20
						end else if (rq.bit_idx > data_bits && !vote) begin
							rd.bad_stop = 1'b1; // R22
						end
						if (rq.bit_idx == last_idx) begin
							rd.st = ast_pkg::AST_RX_HUNT;
							// After a non-break error, hunt restarts at once
							rd.hist = (rd.bad_stop && rd.shreg == 9'h000) ? 3'h0 : 3'h7;
							// A standing framing error blocks any transfer
							if (rq.fe && !rx_clear) begin
								rd.rbf = rd.rbf;
							end else if (rd.rbf) begin
								rd.ovr = 1'b1; // R18
							end else begin
								rd.rbf = 1'b1; // R18
								rd.fe = rd.bad_stop; // R22
								if (cfg.nine_bit) begin
									rd.data = rd.shreg;
								end else begin
									rd.data = {1'b0, rd.shreg[8:1]};
								end
							end
						end
					end
				end
				default: begin
					rd.st = ast_pkg::AST_RX_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rq <= ast_pkg::AST_RX_RESET;
		end else begin
			rq <= rd;
		end
	end

	// Every status output is a flop of the state records
	assign txd_o = tq.txd;
	assign txd_oe_n_o = tq.oe_n;
	assign tx_buffer_empty_o = !tq.tdb_full;
	assign tx_done_flag_o = tq.done;
	assign rx_data_o = rq.data;
	assign rx_buffer_full_o = rq.rbf;
	assign overrun_flag_o = rq.ovr;
	assign frame_error_flag_o = rq.fe;
endmodule

//--- verification/ast_top_assertions.sv
// Port-level assertions of the serial transceiver
`timescale 1ns/1ps
module ast_top_assertions #(
	parameter int BAUD_W = 13
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [BAUD_W-1:0] baud_div_i,
	input wire logic tx_enable_i,
	input wire logic tx_polarity_flip_i,
	input wire logic data_read_i,
	input wire logic txd_o,
	input wire logic txd_oe_n_o,
	input wire logic tx_done_flag_o,
	input wire logic [ast_pkg::AST_DATA_W-1:0] rx_data_o,
	input wire logic rx_buffer_full_o,
	input wire logic overrun_flag_o
);
	// One domain, so one clock and reset for all
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// Idle line rests at the inactive level
	property p_idle;
		tx_done_flag_o && $stable(tx_polarity_flip_i) |-> txd_o != tx_polarity_flip_i;
	endproperty
	a_idle: assert property (p_idle) else $error("idle level wrong");
	// Pin is let go only once nothing is left to send; done and release may rise together
	property p_held;
		$rose(txd_oe_n_o) |-> tx_done_flag_o;
	endproperty
	a_held: assert property (p_held) else $error("pin let go while busy");
	// Pin is only let go once disabled
	property p_release;
		$rose(txd_oe_n_o) |-> !$past(tx_enable_i);
	endproperty
	a_release: assert property (p_release) else $error("pin let go while enabled");
	// Enabling from a released pin opens with an idle frame
	property p_preamble;
		$rose(tx_enable_i) && txd_oe_n_o && !tx_polarity_flip_i |-> txd_o [*8];
	endproperty
	a_preamble: assert property (p_preamble) else $error("no idle preamble");
	// Zero divisor freezes the line
	property p_halt;
		(baud_div_i == '0 && !tx_polarity_flip_i) [*3] |=> $stable(txd_o);
	endproperty
	a_halt: assert property (p_halt) else $error("line moved with divisor zero");
	// Full flag falls only after a data read
	property p_clear;
		$fell(rx_buffer_full_o) |-> $past(data_read_i);
	endproperty
	a_clear: assert property (p_clear) else $error("full flag fell unasked");
	// Overrun only on a full register
	property p_overrun;
		$rose(overrun_flag_o) |-> $past(rx_buffer_full_o);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun while empty");
	// A full register keeps its character
	property p_keep;
		rx_buffer_full_o && $past(rx_buffer_full_o) |-> $stable(rx_data_o);
	endproperty
	a_keep: assert property (p_keep) else $error("held character replaced");
endmodule

bind ast_top ast_top_assertions #(.BAUD_W(BAUD_W)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
	.baud_div_i(baud_div_i), .tx_enable_i(tx_enable_i), .tx_polarity_flip_i(tx_polarity_flip_i),
	.data_read_i(data_read_i), .txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o),
	.tx_done_flag_o(tx_done_flag_o), .rx_data_o(rx_data_o), .rx_buffer_full_o(rx_buffer_full_o),
	.overrun_flag_o(overrun_flag_o));

//--- verification/ast_peer.sv
// Remote serial device model: line decoder and frame sender
`timescale 1ns/1ps
module ast_peer #(
	parameter int BIT = 16
) (
	input wire logic clk_i,
	input wire logic line_i,
	input wire logic nine_i,
	output logic rxd_o,
	output logic got_o,
	output logic [9:0] word_o
);
	int n;

	// Decoder: qualify start at mid-bit, one sample per bit, stop in bit 9
	initial begin
		got_o = 1'b0;
		word_o = '0;
		forever begin
			@(negedge line_i);
			repeat (BIT / 2) @(posedge clk_i);
			if (line_i) continue;
			n = nine_i ? 9 : 8;
			word_o = '0;
			for (int i = 1; i <= n + 1; i++) begin
				repeat (BIT) @(posedge clk_i);
				if (i <= n) word_o[i-1] = line_i; else word_o[9] = line_i;
			end
			got_o = 1'b1;
			@(posedge clk_i);
			got_o = 1'b0;
		end
	end

	// Sender at the exact device rate, well inside the allowed mismatch
	task automatic send(input logic [8:0] d, input logic nine, input logic two,
		input logic stop_ok);
		int m;
		m = nine ? 9 : 8;
		for (int i = 0; i < m + 2 + int'(two); i++) begin
			@(negedge clk_i);
			rxd_o = i == 0 ? 1'b0 : i <= m ? d[i-1] : stop_ok;
			repeat (BIT - 1) @(negedge clk_i);
		end
		@(negedge clk_i);
		rxd_o = 1'b1;
		repeat (2 * BIT) @(negedge clk_i);
	endtask

	// Line idles high, as with a pull-up
	initial rxd_o = 1'b1;
endmodule

//--- verification/ast_top_tb.sv
// Self-checking bench of the serial transceiver
`timescale 1ns/1ps
module ast_top_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [ast_pkg::AST_BAUD_W-1:0] div = 13'h0001;
	logic te = 1'b0, re = 1'b1, tflip = 1'b0, rflip = 1'b0, nine = 1'b0, two = 1'b0;
	logic lbrk = 1'b0, send_break_ctrl = 1'b0, tval = 1'b0, srd = 1'b0, drd = 1'b0, rbf_seen = 1'b0;
	logic [8:0] tdat = 9'h000;
	logic tx_rdy, txd, oe_n, tbe, done, rbf, ovr, fe, prxd, got;
	logic [8:0] rdat;
	logic [9:0] word;
	logic [31:0] seed = 32'h3391;
	logic [9:0] tx_q[$], rx_q[$];
	int brk_q[$];
	int failures = 0, tests_run = 0, lowrun = 0;

	// Clock, 8 ns period
	always #4 clk = ~clk;

	ast_top dut (.clk_i(clk), .reset_i(reset), .baud_div_i(div), .tx_enable_i(te),
		.rx_enable_i(re), .tx_polarity_flip_i(tflip), .rx_polarity_flip_i(rflip),
		.nine_bit_sel_i(nine), .two_stop_sel_i(two), .long_break_sel_i(lbrk),
		.send_break_ctrl_i(send_break_ctrl), .tx_data_i(tdat), .tx_valid_i(tval), .tx_ready_o(tx_rdy),
		.txd_o(txd), .txd_oe_n_o(oe_n), .tx_buffer_empty_o(tbe), .tx_done_flag_o(done),
		.rxd_i(prxd ^ rflip), .status_read_i(srd), .data_read_i(drd), .rx_data_o(rdat),
		.rx_buffer_full_o(rbf), .overrun_flag_o(ovr), .frame_error_flag_o(fe));
	ast_peer peer (.clk_i(clk), .line_i(txd ^ tflip), .nine_i(nine), .rxd_o(prxd),
		.got_o(got), .word_o(word));

	task automatic check(input logic [9:0] seen, input logic [9:0] want);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Xorshift source of stimulus values
	task automatic rng(output logic [8:0] v);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		v = seed[8:0];
	endtask

	// Valid held until an edge with ready high takes the word
	task automatic put(input logic [8:0] d);
		@(negedge clk);
		tdat = d;
		tval = 1'b1;
		while (tx_rdy !== 1'b1) @(negedge clk);
		@(negedge clk);
		tval = 1'b0;
		tx_q.push_back({1'b1, nine ? d : {1'b0, d[7:0]}});
	endtask

	// Bounded wait for the transmitter to go quiet
	task automatic wait_done();
		repeat (8) @(negedge clk);
		for (int i = 0; i < 60000 && done !== 1'b1; i++) @(negedge clk);
	endtask

	// Status read, then data read, then all receive flags gone
	task automatic clear_rx();
		@(negedge clk) srd = 1'b1;
		@(negedge clk) srd = 1'b0;
		drd = 1'b1;
		@(negedge clk) drd = 1'b0;
		@(negedge clk) check({7'h0, ovr, fe, rbf}, 10'h000);
	endtask

	// Scoreboards: oldest note against each character seen
	always @(negedge clk) begin
		if (got) check(word, tx_q.size() ? tx_q.pop_front() : 10'hx);
		if (rbf && !rbf_seen) check({fe, rdat}, rx_q.size() ? rx_q.pop_front() : 10'hx);
		rbf_seen = rbf;
	end

	// Low runs longer than 150 cycles are breaks
	always @(negedge clk) begin
		if (txd ^ tflip) begin
			if (lowrun > 150) check(10'(lowrun), 10'(brk_q.pop_front() * 16));
			lowrun = 0;
		end else lowrun++;
	end

	// Watchdog well past the expected 10k cycles
	initial begin
		#400000;
		failures++;
		wrap_up();
	end

	initial begin
		logic [8:0] v;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		@(negedge clk) check({5'h0, tx_rdy, txd, oe_n, tbe, done}, 10'h01f);
		// Data waits in the FIFO until the transmitter is on
		for (int i = 0; i < ast_pkg::AST_FIFO_DEPTH; i++) begin
			rng(v);
			put(v);
		end
		repeat (4) @(negedge clk);
		check({7'h0, tx_rdy, oe_n, tbe}, 10'h003);
		te = 1'b1;
		wait_done();
		check({9'h0, oe_n}, 10'h000);
		// Remaining formats, back to back
		for (int c = 1; c < 4; c++) begin
			{nine, two} = 2'(c);
			for (int i = 0; i < 3; i++) begin
				rng(v);
				put(v);
			end
			wait_done();
		end
		// One break per format and length
		for (int c = 0; c < 8; c++) begin
			{lbrk, nine, two} = 3'(c);
			@(negedge clk) send_break_ctrl = 1'b1;
			@(negedge clk) send_break_ctrl = 1'b0;
			brk_q.push_back(10 + (lbrk ? 3 : 0) + int'(nine) + int'(two));
			tx_q.push_back(10'h000);
			wait_done();
		end
		// Control still set at the break load gives a second break
		{lbrk, nine, two} = 3'h0;
		@(negedge clk) send_break_ctrl = 1'b1;
		repeat (40) @(negedge clk);
		send_break_ctrl = 1'b0;
		// Two separate breaks, each a full break length, with one idle clock between
		brk_q.push_back(10);
		brk_q.push_back(10);
		tx_q.push_back(10'h000);
		tx_q.push_back(10'h000);
		wait_done();
		// Enable dropped mid-frame: frame completes, then pin let go
		rng(v);
		put(v);
		repeat (40) @(negedge clk);
		te = 1'b0;
		@(negedge clk) check({9'h0, oe_n}, 10'h000);
		wait_done();
		check({8'h0, oe_n, txd}, 10'h003);
		te = 1'b1;
		repeat (8) @(negedge clk);
		check({8'h0, done, txd}, 10'h001);
		wait_done();
		tflip = 1'b1;
		repeat (8) @(negedge clk);
		check({9'h0, txd}, 10'h000);
		tflip = 1'b0;
		div = '0;
		repeat (8) @(negedge clk);
		div = 13'h0001;
		// Every receive format, odd ones through the inverted input
		for (int c = 0; c < 4; c++) begin
			{nine, two} = 2'(c);
			rflip = c[0];
			rng(v);
			rx_q.push_back({1'b0, nine ? v : {1'b0, v[7:0]}});
			peer.send(v, nine, two, 1'b1);
			clear_rx();
		end
		// Second character into a full register is lost
		{nine, two, rflip} = 3'h0;
		rng(v);
		rx_q.push_back({2'b00, v[7:0]});
		peer.send(v, 1'b0, 1'b0, 1'b1);
		peer.send(~v, 1'b0, 1'b0, 1'b1);
		check({ovr, rdat}, {2'b10, v[7:0]});
		clear_rx();
		// Zero stop bit
		rx_q.push_back({2'b10, v[7:0]});
		peer.send(v, 1'b0, 1'b0, 1'b0);
		clear_rx();
		wrap_up();
	end
endmodule
